//--- hdl/interrupt_enable_priority_regs.sv
// interrupt enable and priority special function registers with two-level selection
`timescale 1ns/100ps
`include "irq_regs_consts.svh"

// What this block does, and what it expects of software
// RQ1: global enable at 0 blocks every source; at 1 each source follows its own enable.
// RQ2: software rewrites the debug trace bit with the value it read back.
// RQ3: base enable register holds readable, writable enables for the six base sources.
// RQ4: each enable bit at 1 allows its interrupt, at 0 blocks it.
// RQ5: extra enable register: adc 7, spi 6, counter array 5, uart1 4, i2c 1, usb 0.
// RQ6: software never sets bits 3 and 2 of the extra enable register.
// RQ7: base priority: timer2 5, uart0 4, timer1 3, ext1 2, timer0 1, ext0 0.
// RQ8: priority bit 1 gives the high level, 0 the low level.
// RQ9: extra priority: adc 7, spi 6, counter array 5, uart1 4, i2c 1, usb 0.
// RQ10: reset clears extra enable, base priority and extra priority to zero.
// RQ11: high request preempts low service; equal levels resolved by fixed source order.
// RQ12: request raised only while source flag, own enable and global enable are set.
module interrupt_enable_priority_regs
    import irq_regs_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [7:0]   sfr_addr,
    input  wire logic         sfr_wr,
    input  wire logic [7:0]   sfr_wdata,
    output logic      [7:0]   sfr_rdata,
    output logic              sfr_hit,
    input  wire irq_src_vec_t src_flag,
    input  wire logic         in_service_low,
    input  wire logic         in_service_high,
    output irq_src_vec_t      irq_req,
    output irq_grant_t        grant
);

    // source order 0..11: ext0, timer0, ext1, timer1, uart0, timer2,
    // adc, spi, counter array, uart1, i2c, usb
    function automatic irq_src_vec_t src_vec(
        input logic [7:0] base,
        input logic [7:0] extra
    );
        return {extra[0], extra[1], extra[4], extra[5], extra[6], extra[7], base[5:0]};
    endfunction : src_vec

    // lowest index wins among equal levels
    function automatic logic [`IRQ_ID_WIDTH-1:0] first_set(input irq_src_vec_t v);
        logic [`IRQ_ID_WIDTH-1:0] id;
        id = '0;
        for (int i = `IRQ_SRC_COUNT - 1; i >= 0; i--) begin
            if (v[i]) begin
                id = i[`IRQ_ID_WIDTH-1:0];
            end
        end
        return id;
    endfunction : first_set

    irq_regs_t    regs;
    irq_regs_t    next_regs;
    irq_grant_t   next_grant;
    logic [7:0]   next_rdata;
    irq_src_vec_t enables;
    irq_src_vec_t levels;
    irq_src_vec_t hi_req;
    irq_src_vec_t lo_req;
    logic         wr_enable_base;
    logic         wr_enable_extra;
    logic         wr_priority_base;
    logic         wr_priority_extra;

    assign wr_enable_base    = sfr_wr && (sfr_addr == `IRQ_ENABLE_BASE_ADDR);
    assign wr_enable_extra   = sfr_wr && (sfr_addr == `IRQ_ENABLE_EXTRA_ADDR);
    assign wr_priority_base  = sfr_wr && (sfr_addr == `IRQ_PRIORITY_BASE_ADDR);
    assign wr_priority_extra = sfr_wr && (sfr_addr == `IRQ_PRIORITY_EXTRA_ADDR);

    assign sfr_hit = (sfr_addr == `IRQ_ENABLE_BASE_ADDR)
                  || (sfr_addr == `IRQ_ENABLE_EXTRA_ADDR)
                  || (sfr_addr == `IRQ_PRIORITY_BASE_ADDR)
                  || (sfr_addr == `IRQ_PRIORITY_EXTRA_ADDR);

    always_comb begin
        // the global bit masks all twelve sources at once
        enables = src_vec(regs.enable_base, regs.enable_extra)
                & {`IRQ_SRC_COUNT{regs.enable_base[`IRQ_GLOBAL_BIT]}}; // RQ1 RQ4
        levels  = src_vec(regs.priority_base, regs.priority_extra); // RQ8
        irq_req = src_flag & enables; // RQ12
        hi_req  = irq_req & levels;
        lo_req  = irq_req & ~levels;

        next_regs = regs;
        // trace bit is stored as written; keeping it intact is up to software
        if (wr_enable_base) begin
            next_regs.enable_base = sfr_wdata & `IRQ_ENABLE_BASE_MASK; // RQ3
        end
        // reserved positions never store, so they cannot enable a phantom source
        if (wr_enable_extra) begin
            next_regs.enable_extra = sfr_wdata & `IRQ_EXTRA_MASK; // RQ5 RQ6
        end
        if (wr_priority_base) begin
            next_regs.priority_base = sfr_wdata & `IRQ_PRIORITY_BASE_MASK; // RQ7
        end
        if (wr_priority_extra) begin
            next_regs.priority_extra = sfr_wdata & `IRQ_EXTRA_MASK; // RQ9
        end

        case (sfr_addr)
            `IRQ_ENABLE_BASE_ADDR:    next_rdata = regs.enable_base;
            `IRQ_ENABLE_EXTRA_ADDR:   next_rdata = regs.enable_extra;
            `IRQ_PRIORITY_BASE_ADDR:  next_rdata = regs.priority_base;
            `IRQ_PRIORITY_EXTRA_ADDR: next_rdata = regs.priority_extra;
            default:                  next_rdata = 8'h00;
        endcase

        next_grant = '0;
        // a high request may break into low service but never into high service
        if ((|hi_req) && !in_service_high) begin
            next_grant.valid = 1'b1; // RQ11
            next_grant.high  = 1'b1;
            next_grant.id    = first_set(hi_req); // RQ11
        end else if ((|lo_req) && !in_service_high && !in_service_low) begin
            next_grant.valid = 1'b1;
            next_grant.high  = 1'b0;
            next_grant.id    = first_set(lo_req); // RQ11
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regs.enable_base    <= `IRQ_REG_RESET;
            regs.enable_extra   <= `IRQ_REG_RESET; // RQ10
            regs.priority_base  <= `IRQ_REG_RESET; // RQ10
            regs.priority_extra <= `IRQ_REG_RESET; // RQ10
            sfr_rdata           <= 8'h00;
            grant               <= '0;
        end else begin
            regs      <= next_regs;
            sfr_rdata <= next_rdata;
            grant     <= next_grant;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_global_blocks_all: assert property ( // RQ1
        !regs.enable_base[`IRQ_GLOBAL_BIT] |-> (irq_req == '0) && !next_grant.valid
    ) else $error("request seen while global enable is clear");

    a_ext0_req_gate: assert property ( // RQ12
        (src_flag[0] && regs.enable_base[0] && regs.enable_base[`IRQ_GLOBAL_BIT])
            == irq_req[0]
    ) else $error("ext0 request does not follow flag and enables");

    a_usb_enable_block: assert property ( // RQ4
        !regs.enable_extra[0] |-> !irq_req[11]
    ) else $error("usb request passes with its enable clear");

    a_base_enable_write: assert property ( // RQ3
        wr_enable_base |=> regs.enable_base == $past(sfr_wdata)
    ) else $error("base enable write not stored");

    a_extra_enable_write: assert property ( // RQ5
        wr_enable_extra |=> regs.enable_extra == ($past(sfr_wdata) & 8'hf3)
    ) else $error("extra enable write stored wrongly");

    a_prio_base_write: assert property ( // RQ7
        wr_priority_base |=> regs.priority_base == ($past(sfr_wdata) & 8'h3f)
    ) else $error("base priority write stored wrongly");

    a_prio_extra_write: assert property ( // RQ9
        wr_priority_extra |=> regs.priority_extra == ($past(sfr_wdata) & 8'hf3)
    ) else $error("extra priority write stored wrongly");

    a_reserved_stay_zero: assert property ( // RQ7
        (regs.priority_base[7:6] == 2'b00) && (regs.priority_extra[3:2] == 2'b00)
            && (regs.enable_extra[3:2] == 2'b00)
    ) else $error("reserved bit became set");

    a_reset_clears: assert property ( // RQ10
        @(posedge clk) disable iff (1'b0)
        $rose(rst_b) |-> (regs.enable_extra == 8'h00) && (regs.priority_base == 8'h00)
            && (regs.priority_extra == 8'h00)
    ) else $error("registers not cleared by reset");

    a_high_preempts_low: assert property ( // RQ11
        ((|hi_req) && in_service_low && !in_service_high)
            |=> grant.valid && grant.high && (grant.id == $past(first_set(hi_req)))
    ) else $error("high request did not preempt low service");

    a_low_waits_service: assert property ( // RQ11
        ((hi_req == '0) && (in_service_low || in_service_high)) |=> !grant.valid
    ) else $error("low request granted during service");

    a_adc_level_high: assert property ( // RQ8
        (irq_req[6] && regs.priority_extra[7] && (hi_req[5:0] == '0) && !in_service_high)
            |=> grant.valid && grant.high && (grant.id == 4'h6)
    ) else $error("adc with high level not granted high");

    a_read_back: assert property ( // RQ3
        (sfr_addr == `IRQ_ENABLE_BASE_ADDR) |=> sfr_rdata == $past(regs.enable_base)
    ) else $error("base enable read back differs");

    a_prio_extra_read: assert property ( // RQ9
        (sfr_addr == `IRQ_PRIORITY_EXTRA_ADDR) |=> sfr_rdata == $past(regs.priority_extra)
    ) else $error("extra priority read back differs");

    a_adc_enable_map: assert property ( // RQ5
        regs.enable_base[`IRQ_GLOBAL_BIT] |-> irq_req[6] == (src_flag[6] && regs.enable_extra[7])
    ) else $error("adc request does not follow its enable bit");

    a_high_blocked_service: assert property ( // RQ11
        in_service_high |=> !grant.valid
    ) else $error("grant offered during high level service");

    a_low_lowest_first: assert property ( // RQ11
        ((hi_req == '0) && lo_req[0] && !in_service_low && !in_service_high)
            |=> grant.valid && !grant.high && (grant.id == 4'h0)
    ) else $error("lowest source not chosen among low requests");

    a_timer2_level_map: assert property ( // RQ7
        (irq_req[5] && regs.priority_base[5] && (hi_req[4:0] == '0) && !in_service_high)
            |=> grant.valid && grant.high && (grant.id == 4'h5)
    ) else $error("timer2 with high level not granted high");

    c_preempt: cover property (in_service_low && (|hi_req) ##1 grant.high);
    c_global_off_flag: cover property (!regs.enable_base[`IRQ_GLOBAL_BIT] && (|src_flag));
    c_two_low_same: cover property ($countones(lo_req) > 1 && !in_service_low);
    c_extra_write: cover property (wr_enable_extra && (sfr_wdata[7:4] != 4'h0));

endmodule : interrupt_enable_priority_regs

//--- hdl/irq_regs_consts.svh
// offsets, reset values and field positions of the interrupt enable and priority registers
`ifndef IRQ_REGS_CONSTS_SVH
`define IRQ_REGS_CONSTS_SVH

`define IRQ_ENABLE_BASE_ADDR    8'ha8
`define IRQ_ENABLE_EXTRA_ADDR   8'ha7
`define IRQ_PRIORITY_EXTRA_ADDR 8'hb7
`define IRQ_PRIORITY_BASE_ADDR  8'hb8

`define IRQ_REG_RESET           8'h00

`define IRQ_GLOBAL_BIT          7
`define IRQ_TRACE_BIT           6

`define IRQ_ENABLE_BASE_MASK    8'hff
`define IRQ_EXTRA_MASK          8'hf3
`define IRQ_PRIORITY_BASE_MASK  8'h3f

`define IRQ_SRC_COUNT           12
`define IRQ_ID_WIDTH            4

`endif

//--- hdl/irq_regs_pkg.sv
// types shared by the interrupt enable and priority register bank
`include "irq_regs_consts.svh"

package irq_regs_pkg;

    typedef logic [`IRQ_SRC_COUNT-1:0] irq_src_vec_t;

    typedef struct packed {
        logic [7:0] enable_base;
        logic [7:0] enable_extra;
        logic [7:0] priority_base;
        logic [7:0] priority_extra;
    } irq_regs_t;

    typedef struct packed {
        logic                     valid;
        logic                     high;
        logic [`IRQ_ID_WIDTH-1:0] id;
    } irq_grant_t;

endpackage : irq_regs_pkg

//--- tb/interrupt_enable_priority_regs_tb_top.sv
// self-checking bench for the interrupt enable and priority register bank
`timescale 1ns/100ps
module interrupt_enable_priority_regs_tb_top
    import irq_regs_pkg::*;
;
    typedef struct packed {
        logic [1:0]  kind;
        logic [11:0] val;
    } note_t;
    logic         clk, rst_b, sfr_wr, sfr_hit, in_service_low, in_service_high;
    logic [7:0]   sfr_addr, sfr_wdata, sfr_rdata;
    irq_src_vec_t src_flag, irq_req;
    irq_grant_t   grant;
    note_t        q[$];
    event         look;
    int           err_count, checks_done, cycles;
    logic [31:0]  seed;
    logic [7:0]   adr[5] = '{8'ha8, 8'ha7, 8'hb8, 8'hb7, 8'h55};
    // trace bit reads 0 because the core always writes back what it read
    logic [7:0]   msk[5] = '{8'hbf, 8'hf3, 8'h3f, 8'hf3, 8'h00};

    interrupt_enable_priority_regs interrupt_enable_priority_regs_i (.clk, .rst_b, .sfr_addr,
        .sfr_wr, .sfr_wdata, .sfr_rdata, .sfr_hit, .src_flag, .in_service_low,
        .in_service_high, .irq_req, .grant);
    irq_core_model irq_core_model_i (.clk, .sfr_rdata, .sfr_addr, .sfr_wr, .sfr_wdata,
        .src_flag, .in_service_low, .in_service_high);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [11:0] spread(input logic [7:0] b, input logic [7:0] x);
        return {x[0], x[1], x[4], x[5], x[6], x[7], b[5:0]};
    endfunction : spread
    function automatic logic [5:0] pick(input logic [11:0] r, input logic [11:0] p,
                                        input logic lo, input logic hi);
        pick = 6'h00;
        for (int i = 11; i >= 0; i--) if (r[i] && p[i] && !hi) pick = {2'h3, i[3:0]};
        if (pick == 6'h00)
            for (int i = 11; i >= 0; i--) if (r[i] && !p[i] && !lo && !hi) pick = {2'h2, i[3:0]};
    endfunction : pick

    task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // every register reads zero and only the four mapped addresses hit
    task automatic read_zero;
        for (int i = 0; i < 5; i++) begin
            irq_core_model_i.rd(adr[i]);
            q.push_back('{2'h0, 12'h000});
            q.push_back('{2'h3, {11'h000, i < 4}});
            -> look;
        end
    endtask : read_zero
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    always @(look) begin
        note_t      n;
        logic [5:0] g;
        while (q.size() > 0) begin
            n = q.pop_front();
            g = grant;
            if (!n.val[5]) g[4:0] = 5'h00;
            case (n.kind)
                2'h0: check("rdata", {4'h0, sfr_rdata}, n.val);
                2'h1: check("irq_req", irq_req, n.val);
                2'h3: check("sfr_hit", {11'h000, sfr_hit}, n.val);
                default: check("grant", {6'h00, g}, n.val);
            endcase
        end
    end

    // a few hundred cycles are expected, so this only trips on a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        logic [7:0]  eb, ex;
        logic [11:0] r;
        logic [11:0] e;
        seed = 32'h0000_45c5;
        rst_b = 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        read_zero();
        for (int i = 0; i < 5; i++) begin
            if (i == 0) irq_core_model_i.wr_base(8'hff);
            else irq_core_model_i.wr(adr[i], (i == 1) ? 8'hf3 : 8'hff);
            irq_core_model_i.rd(adr[i]);
            q.push_back('{2'h0, {4'h0, msk[i]}});
            -> look;
        end
        for (int i = 0; i < 40; i++) begin
            repeat (32) seed = lfsr(seed);
            eb = seed[7:0];
            ex = seed[15:8] & 8'hf3;
            irq_core_model_i.wr_base(eb);
            irq_core_model_i.wr(8'ha7, ex);
            irq_core_model_i.wr(8'hb8, seed[23:16]);
            irq_core_model_i.wr(8'hb7, seed[31:24]);
            r = spread(seed[23:16], seed[31:24]);
            repeat (32) seed = lfsr(seed);
            irq_core_model_i.src(seed[11:0], seed[12] & seed[14], seed[13] & seed[15]);
            @(negedge clk);
            e = seed[11:0] & spread(eb, ex) & {12{eb[7]}};
            q.push_back('{2'h1, e});
            q.push_back('{2'h2, {6'h00, pick(e, r, in_service_low,
                                            in_service_high)}});
            -> look;
        end
        // reset again with every register loaded, then all must read zero
        @(negedge clk) rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        read_zero();
        summarize();
    end
endmodule : interrupt_enable_priority_regs_tb_top

//--- tb/irq_core_model.sv
// core and interrupt source model facing the register bank
`timescale 1ns/100ps
`include "irq_regs_consts.svh"
module irq_core_model
    import irq_regs_pkg::*;
(
    input  wire logic         clk,
    input  wire logic [7:0]   sfr_rdata,
    output logic      [7:0]   sfr_addr,
    output logic              sfr_wr,
    output logic      [7:0]   sfr_wdata,
    output irq_src_vec_t      src_flag,
    output logic              in_service_low,
    output logic              in_service_high
);
    initial begin
        {sfr_addr, sfr_wr, sfr_wdata} = 17'h0_0000;
        {src_flag, in_service_low, in_service_high} = 14'h0000;
    end
    task automatic rd(input logic [7:0] a);
        @(negedge clk) sfr_addr = a;
        @(negedge clk);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) {sfr_addr, sfr_wr, sfr_wdata} = {a, 1'b1, d};
        @(negedge clk) sfr_wr = 1'b0;
    endtask : wr
    // read first so the debugger's trace setting survives
    task automatic wr_base(input logic [7:0] d);
        rd(`IRQ_ENABLE_BASE_ADDR);
        wr(`IRQ_ENABLE_BASE_ADDR, {d[7], sfr_rdata[6], d[5:0]});
    endtask : wr_base
    task automatic src(input logic [11:0] f, input logic lo, input logic hi);
        @(negedge clk) {src_flag, in_service_low, in_service_high} = {f, lo, hi};
    endtask : src
endmodule : irq_core_model
